// ### hdl/pdt_timer.sv
// prescaled down-counter timer with control register
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module pdt_timer
    import pdt_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic por_i,
    input wire logic cycle_clk_i,
    input wire logic count_pin_i,
    input wire logic core_imask_i,
    input wire logic core_wait_i,
    input wire logic core_stop_i,
    input wire logic irq_ack_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output logic [15:0] vector_o
);
    typedef struct packed {
        logic [PDT_CNT_W-1:0] counter;
        logic [PDT_PRE_W-1:0] prescaler;
        logic flag;
        logic mask;
        logic src;
        logic pin_en;
        logic [PDT_TAP_W-1:0] tap;
        logic pending;
        logic stop_prev;
        logic [7:0] rdata;
    } pdt_state_t;

    pdt_state_t st_r;
    pdt_state_t st_nxt;
    logic tick;
    logic stop_entry;
    logic cnt_wr;
    logic ctl_wr;
    logic cnt_rd;
    logic [PDT_PRE_W:0] pre_ext;
    logic [PDT_PRE_W:0] pre_inc;
    logic cnt_step;
    logic hit_zero;

    // tap n steps when prescaler bit n-1 falls: divide by 2^n
    function automatic logic tap_step(input logic [PDT_PRE_W:0] nowv,
                                      input logic [PDT_PRE_W:0] nextv,
                                      input logic [PDT_TAP_W-1:0] sel);
        logic [PDT_PRE_W:0] chg;
        chg = nowv ^ nextv;
        tap_step = (sel == '0) ? 1'b1 :
                   (chg[sel - 3'd1] & ~nextv[sel - 3'd1]);
    endfunction : tap_step

    //----------------------------------------------------------------
    // count input
    //----------------------------------------------------------------
    pdt_edge_src u_src (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .cycle_clk_i(cycle_clk_i),
        .count_pin_i(count_pin_i),
        .mode_i({st_r.src, st_r.pin_en}),
        .tick_o(tick)
    );

    assign stop_entry = core_stop_i & ~st_r.stop_prev;
    assign cnt_wr = wr_i & (addr_i == PDT_ADDR_COUNTER);
    assign ctl_wr = wr_i & (addr_i == PDT_ADDR_CONTROL);
    assign cnt_rd = rd_i & (addr_i == PDT_ADDR_COUNTER);

    //----------------------------------------------------------------
    // prescaler and counter step
    //----------------------------------------------------------------
    always_comb begin
        // stop halts the oscillator: no advance while stopped [R16]
        pre_ext = {1'b0, st_r.prescaler};
        pre_inc = pre_ext + 8'h01;
        cnt_step = tick & ~core_stop_i & tap_step(pre_ext, pre_inc,
                                                  st_r.tap); // [R9] [R10]
        hit_zero = cnt_step & (st_r.counter == PDT_CNT_ONE) & ~cnt_wr; // [R2]
    end

    //----------------------------------------------------------------
    // next state
    //----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.stop_prev = core_stop_i;
        // tick is only a falling edge; wait does not gate it [R13] [R18]
        if (tick && !core_stop_i) begin
            st_nxt.prescaler = pre_inc[PDT_PRE_W-1:0]; // [R1] [R14]
        end
        if (cnt_step) begin
            st_nxt.counter = st_r.counter - PDT_CNT_ONE; // [R1] [R4]
        end
        // read never changes count; read data registered [R5]
        st_nxt.rdata = PDT_ZERO8;
        if (rd_i) begin
            unique case (addr_i)
                PDT_ADDR_COUNTER: st_nxt.rdata = st_r.counter; // [R5]
                PDT_ADDR_CONTROL: st_nxt.rdata = {st_r.flag, st_r.mask,
                    st_r.src, st_r.pin_en, 1'b0, st_r.tap}; // [R11]
                PDT_ADDR_VECTOR: st_nxt.rdata = vector_o[7:0];
                default: st_nxt.rdata = PDT_ZERO8;
            endcase
        end
        if (cnt_wr) begin
            st_nxt.counter = wdata_i; // [R20]
        end
        if (ctl_wr) begin
            st_nxt.flag = wdata_i[PDT_FLAG_BIT];
            st_nxt.mask = wdata_i[PDT_MASK_BIT];
            st_nxt.src = wdata_i[PDT_SRC_BIT];
            st_nxt.pin_en = wdata_i[PDT_PIN_BIT];
            st_nxt.tap = wdata_i[PDT_TAP_HI:0]; // [R9]
            if (wdata_i[PDT_PCLR_BIT]) begin
                st_nxt.prescaler = '0; // [R11]
            end
        end
        // flag and pending stay until software or service [R6]
        if (irq_ack_i || cnt_rd) begin
            st_nxt.pending = 1'b0; // [R7]
        end
        if (hit_zero) begin
            st_nxt.flag = 1'b1; // [R2] [R8]
            st_nxt.pending = 1'b1;
        end
        if (ctl_wr && !wdata_i[PDT_FLAG_BIT] && !hit_zero) begin
            st_nxt.pending = 1'b0;
        end
        if (stop_entry) begin
            st_nxt.flag = 1'b0; // [R16]
            st_nxt.mask = 1'b1; // [R16]
            st_nxt.pending = 1'b0;
            st_nxt.prescaler = '0; // [R16]
            st_nxt.counter = PDT_CNT_INIT; // [R15]
        end
        if (por_i) begin
            st_nxt.counter = PDT_CNT_INIT; // [R15]
        end
    end

    // irq needs flag, pending, no mask, core unmasked [R3] [R7]
    assign irq_o = st_r.flag & st_r.pending & ~st_r.mask & ~core_imask_i;
    assign vector_o = core_wait_i ? PDT_VEC_WAIT : PDT_VEC_RUN; // [R19]
    assign rdata_o = st_r.rdata;

    //----------------------------------------------------------------
    // state register
    //----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_r.flag <= 1'b0; // [R17]
            st_r.mask <= 1'b1; // [R17]
            st_r.pending <= 1'b0;
            st_r.stop_prev <= 1'b0;
            st_r.rdata <= PDT_ZERO8;
            if (por_i) begin
                st_r.counter <= PDT_CNT_INIT; // [R15]
                st_r.prescaler <= '0;
                st_r.src <= 1'b0;
                st_r.pin_en <= 1'b0;
                st_r.tap <= '0;
            end
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end
endmodule : pdt_timer

// ### hdl/pdt_pkg.sv
// constants and encodings for the prescaled down-counter timer
//----------------------------------------------------------------
// Summary of operation
// R1: loadable 8-bit down counter, 7-bit prescaler
// R2: counter reaching zero sets request flag
// R3: irq only when flag, no mask, core unmasked
// R4: counter keeps decrementing past zero
// R5: counter reads never disturb counting
// R6: flag stays set until software clears
// R7: counter read before service drops interrupt
// R8: masked flag still sets for polling
// R9: tap select bits 0-2; prescaler hidden
// R10: taps divide by 1 to 128
// R11: bit 3 clears prescaler, reads zero
// R12: source and pin bits choose count input
// R13: internal source is cycle clock, runs in wait
// R14: advance on falling edge of count input
// R15: power-on or stop loads counter F0
// R16: stop clears flag, sets mask, clears prescaler
// R17: resets clear flag, set mask only; power-on reset also clears prescaler, src, pin_en and tap
// R18: timer keeps counting during wait
// R19: vector 1FF8/1FF9, or 1FF6/1FF7 from wait
// R20: counter writes take effect at data strobe
// R21: disabled input holds prescaler and counter
//----------------------------------------------------------------
package pdt_pkg;
    localparam logic [1:0] PDT_ADDR_COUNTER = 2'h0;
    localparam logic [1:0] PDT_ADDR_CONTROL = 2'h1;
    localparam logic [1:0] PDT_ADDR_VECTOR = 2'h2;
    localparam int PDT_FLAG_BIT = 7;
    localparam int PDT_MASK_BIT = 6;
    localparam int PDT_SRC_BIT = 5;
    localparam int PDT_PIN_BIT = 4;
    localparam int PDT_PCLR_BIT = 3;
    localparam int PDT_TAP_HI = 2;
    localparam int PDT_TAP_W = 3;
    localparam int PDT_PRE_W = 7;
    localparam int PDT_CNT_W = 8;
    localparam logic [7:0] PDT_CNT_INIT = 8'hF0;
    localparam logic [7:0] PDT_CNT_ONE = 8'h01;
    localparam logic [7:0] PDT_ZERO8 = 8'h00;
    localparam logic [15:0] PDT_VEC_RUN = 16'h1FF8;
    localparam logic [15:0] PDT_VEC_WAIT = 16'h1FF6;
    localparam logic [1:0] PDT_MODE_INT = 2'b00;
    localparam logic [1:0] PDT_MODE_AND = 2'b01;
    localparam logic [1:0] PDT_MODE_OFF = 2'b10;
    localparam logic [1:0] PDT_MODE_PIN = 2'b11;
endpackage : pdt_pkg

// ### hdl/pdt_edge_src.sv
// count-input selection, pin sync and falling-edge detect
`timescale 1ns/100ps
module pdt_edge_src
    import pdt_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic cycle_clk_i,
    input wire logic count_pin_i,
    input wire logic [1:0] mode_i,
    output logic tick_o
);
    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic sel_prev;
    } pdt_src_state_t;

    pdt_src_state_t st_r;
    pdt_src_state_t st_nxt;
    logic sel;

    //----------------------------------------------------------------
    // source mux
    //----------------------------------------------------------------
    always_comb begin
        unique case (mode_i)
            PDT_MODE_INT: sel = cycle_clk_i; // [R12] [R13]
            PDT_MODE_AND: sel = cycle_clk_i & st_r.pin_s2; // [R12]
            PDT_MODE_OFF: sel = 1'b0; // [R12] [R21]
            PDT_MODE_PIN: sel = st_r.pin_s2; // [R12]
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_s1 = count_pin_i;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.sel_prev = sel;
    end

    // falling edge of the chosen input
    assign tick_o = clk_en_i & st_r.sel_prev & ~sel; // [R14]

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else if (clk_en_i) begin
            st_r <= st_nxt;
        end
    end
endmodule : pdt_edge_src

// ### verif/pdt_timer_assertions.sv
// port-level assertion checker for the timer
`timescale 1ns/100ps
module pdt_timer_assertions
    import pdt_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire logic por_i,
    input wire logic cycle_clk_i,
    input wire logic count_pin_i,
    input wire logic core_imask_i,
    input wire logic core_wait_i,
    input wire logic core_stop_i,
    input wire logic irq_ack_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic irq_o,
    input wire logic [15:0] vector_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    wire rd_cnt = rd_i && addr_i == PDT_ADDR_COUNTER;
    wire rd_ctl = rd_i && addr_i == PDT_ADDR_CONTROL;
    vec_sel_a: assert property (
        vector_o == (core_wait_i ? PDT_VEC_WAIT : PDT_VEC_RUN))
        else $error("vector wrong");
    irq_gate_a: assert property (irq_o |-> !core_imask_i)
        else $error("irq while core masked");
    rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not idle");
    ctl_bit3_a: assert property (rd_ctl |=> !rdata_o[3])
        else $error("clear bit reads one");
    stop_cnt_a: assert property (
        core_stop_i && $past(core_stop_i, 2) && rd_cnt |=>
        rdata_o == PDT_CNT_INIT) else $error("counter not F0 in stop");
    stop_ctl_a: assert property (
        core_stop_i && $past(core_stop_i, 2) && rd_ctl |=>
        rdata_o[7:6] == 2'b01) else $error("flag or mask wrong in stop");
    cnt_step_a: assert property (rd_cnt ##1 rd_cnt |=>
        8'($past(rdata_o) - rdata_o) <= 8'h01)
        else $error("counter jumped between reads");
    irq_drop_a: assert property (rd_cnt |=> !irq_o)
        else $error("irq kept after counter read");
    irq_c: cover property (irq_o);
    stop_rd_c: cover property (core_stop_i && rd_cnt);
    wait_rd_c: cover property (core_wait_i && rd_cnt);
endmodule : pdt_timer_assertions
bind pdt_timer pdt_timer_assertions pdt_timer_assertions_i (.*);

// ### verif/pdt_src_model.sv
// count source model: cycle clock and count pin
`timescale 1ns/100ps
module pdt_src_model (
    input wire logic clk_sys_i,
    output logic cycle_clk_o = 1'b1,
    output logic count_pin_o = 1'b1
);
    // n falls, each half w cycles long
    task automatic edges(input int n, input bit pin, input int w);
        repeat (n) begin
            if (pin) count_pin_o <= 1'b0;
            else cycle_clk_o <= 1'b0;
            repeat (w) @(posedge clk_sys_i);
            count_pin_o <= 1'b1;
            cycle_clk_o <= 1'b1;
            repeat (w) @(posedge clk_sys_i);
        end
        repeat (8) @(posedge clk_sys_i);
    endtask : edges
endmodule : pdt_src_model

// ### verif/pdt_timer_test.sv
// self-checking bench for the prescaled down-counter timer
`timescale 1ns/100ps
module pdt_timer_test;
    import pdt_pkg::*;
    logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, por_i = 1'b1;
    logic clk_en_i = 1'b1, irq_ack_i = 1'b0, core_imask_i = 1'b0;
    logic core_wait_i = 1'b0, core_stop_i = 1'b0, wr_i = 1'b0;
    logic rd_i = 1'b0, rd_d = 1'b0, cycle_clk_i, count_pin_i, irq_o;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, v;
    logic [15:0] vector_o;
    logic [7:0] exp_q[$];
    int n_mismatch = 0, check_count = 0, cycles = 0, t;
    int seed = 32'h0000_5d74;
    always #2.5 clk_sys_i = ~clk_sys_i;
    pdt_timer pdt_timer_i (.*);
    pdt_src_model pdt_src_model_i (.clk_sys_i(clk_sys_i),
        .cycle_clk_o(cycle_clk_i), .count_pin_o(count_pin_i));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e, int n = 1);
        addr_i <= a;
        rd_i <= 1'b1;
        repeat (n) exp_q.push_back(e);
        repeat (n) @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : rd
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    always @(posedge clk_sys_i) begin
        rd_d <= rd_i;
        cycles <= cycles + 1;
        if (rd_d) chk({8'h00, rdata_o}, {8'h00, exp_q.pop_front()});
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        por_i <= 1'b0;
        rd(2'h1, 8'h40);
        rd(2'h0, PDT_CNT_INIT);
        wr(2'h1, 8'h20);
        v = 8'($random(seed));
        wr(2'h0, v);
        pdt_src_model_i.edges(4, 1'b0, 3);
        rd(2'h0, v, 2);
        wr(2'h1, 8'h08);
        rd(2'h1, 8'h00);
        wr(2'h0, 8'h03);
        pdt_src_model_i.edges(3, 1'b0, 1);
        chk(16'(irq_o), 16'h0001);
        pdt_src_model_i.edges(2, 1'b0, 3);
        rd(2'h0, 8'hFE);
        @(posedge clk_sys_i);
        chk(16'(irq_o), 16'h0000);
        rd(2'h1, 8'h80);
        for (t = 0; t < 8; t++) begin
            wr(2'h1, 8'(8'h48 | t));
            wr(2'h0, 8'h10);
            pdt_src_model_i.edges(2 << t, 1'b0, 1);
            rd(2'h0, 8'h0E);
            rd(2'h1, 8'(8'h40 | t));
        end
        wr(2'h1, 8'h78);
        wr(2'h0, 8'h20);
        pdt_src_model_i.edges(3, 1'b1, 3);
        pdt_src_model_i.edges(2, 1'b0, 3);
        rd(2'h0, 8'h1D);
        core_wait_i <= 1'b1;
        wr(2'h1, 8'h08);
        wr(2'h0, 8'h05);
        chk(vector_o, PDT_VEC_WAIT);
        pdt_src_model_i.edges(2, 1'b0, 3);
        rd(2'h0, 8'h03);
        core_wait_i <= 1'b0;
        core_stop_i <= 1'b1;
        pdt_src_model_i.edges(2, 1'b0, 3);
        rd(2'h1, 8'h40);
        rd(2'h0, PDT_CNT_INIT, 2);
        repeat (2) @(posedge clk_sys_i);
        finish_test();
    end
endmodule : pdt_timer_test
